// ---- verilog/ccdseq_pkg.sv ----
// Purpose: shared constants, types and decode functions for the readout-mode sequencer
// Assumes: 25 MHz system clock; sensor array driven as ROWS vertical lines
// Notes:   line counts of the full-area modes derive from ROWS
// Contract
// - progressive scan delivers every line once, non-interlaced, one full frame
// - progressive scan reads all pixels in one simultaneous readout pulse
// - 2/8-line mode reads lines 1 and 6 of each eight, whole area
// - 2/8-line decimated readout delivers array line 1 first
// - 2/4-line mode reads lines 3 and 4 of each four, whole area
// - 2-line addition: read 3,4, shift register two stages, read 1,2 to add
// - center modes 1 and 2 sweep top and bottom, output central 1136 rows
// - center modes 1 and 2 output 568 lines fast rate, 434 slow rate
// - center modes 1 and 2 limit line count for about 30 frames per second
// - center mode 3 progressive, swept, 580 lines fast, 444 slow
// - AF mode 1 sweeps, outputs central 940 rows by 2/8-line readout
// - AF mode 1 outputs 235 lines fast rate, 170 slow rate
package ccdseq_pkg;
    localparam int          CLK_MHZ       = 25;
    localparam int          READOUT_NS    = 4000;
    localparam int          READOUT_CYC   = (READOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int          SHIFT_CYC     = 2;
    localparam logic [10:0] ROWS          = 11'h4d8;
    localparam logic [10:0] LINES_CS_FAST = 11'h238;
    localparam logic [10:0] LINES_CS_SLOW = 11'h1b2;
    localparam logic [10:0] LINES_C3_FAST = 11'h244;
    localparam logic [10:0] LINES_C3_SLOW = 11'h1bc;
    localparam logic [10:0] LINES_AF_FAST = 11'h0eb;
    localparam logic [10:0] LINES_AF_SLOW = 11'h0aa;
    localparam logic [2:0]  GRP_A         = 3'h1;
    localparam logic [2:0]  GRP_B         = 3'h2;
    localparam logic [2:0]  GRP_C         = 3'h4;
    localparam logic [2:0]  GRP_ALL       = 3'h7;

    typedef enum logic [2:0] {
        CCDSEQ_PROG = 3'h0,
        CCDSEQ_D28  = 3'h1,
        CCDSEQ_D24  = 3'h2,
        CCDSEQ_ADD2 = 3'h3,
        CCDSEQ_CS1  = 3'h4,
        CCDSEQ_CS2  = 3'h5,
        CCDSEQ_CS3  = 3'h6,
        CCDSEQ_AF1  = 3'h7
    } ccdseq_mode_e;

    // electrode groups pulsed by the first readout
    function automatic logic [2:0] ccdseq_first_grp(input ccdseq_mode_e m);
        case (m)
            CCDSEQ_D28, CCDSEQ_AF1:                return GRP_A;
            CCDSEQ_D24, CCDSEQ_ADD2,
            CCDSEQ_CS1, CCDSEQ_CS2:                return GRP_C;
            default:                               return GRP_ALL;
        endcase
    endfunction

    function automatic logic ccdseq_adds(input ccdseq_mode_e m);
        return (m == CCDSEQ_ADD2) || (m == CCDSEQ_CS2);
    endfunction

    // array rows consumed per delivered line, as a shift amount
    function automatic logic [1:0] ccdseq_ratio_sh(input ccdseq_mode_e m);
        case (m)
            CCDSEQ_D28, CCDSEQ_AF1: return 2'h2;
            CCDSEQ_PROG, CCDSEQ_CS3: return 2'h0;
            default:                return 2'h1;
        endcase
    endfunction

    function automatic logic [10:0] ccdseq_lines(input ccdseq_mode_e m, input logic fast);
        case (m)
            CCDSEQ_CS1, CCDSEQ_CS2: return fast ? LINES_CS_FAST : LINES_CS_SLOW;
            CCDSEQ_CS3:             return fast ? LINES_C3_FAST : LINES_C3_SLOW;
            CCDSEQ_AF1:             return fast ? LINES_AF_FAST : LINES_AF_SLOW;
            default:                return ROWS >> ccdseq_ratio_sh(m);
        endcase
    endfunction

    // rows swept away above the read region; same count below
    function automatic logic [10:0] ccdseq_sweep(input ccdseq_mode_e m, input logic fast);
        logic [10:0] used;
        used = ccdseq_lines(m, fast) << ccdseq_ratio_sh(m);
        return (ROWS - used) >> 1;
    endfunction
endpackage

// ---- verilog/ccdseq_stream_if.sv ----
// Purpose: valid/ready word stream between sequencer parts
// Assumes: single clock domain
// Notes:   word taken on a clock edge with valid and ready both high
`timescale 1ns/10ps
`default_nettype none
interface ccdseq_stream_if #(parameter int W = 12);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- verilog/ccdseq_fifo.sv ----
// Purpose: pixel buffer between sensor sampling and the output port
// Assumes: single clock, asynchronous active-high reset
// Notes:   full and empty are exact; depth is a power of two
`timescale 1ns/10ps
`default_nettype none
module ccdseq_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 32
) (
    input  wire logic   clk,
    input  wire logic   rst,
    ccdseq_stream_if.snk wr,
    ccdseq_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("depth must be a power of two, at least 2");
        end
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;
    logic         full;
    logic         empty;

    assign empty    = (wp_q == rp_q);
    assign full     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (wr.valid && !full) begin
            mem[wp_q[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
        end else if (wr.valid && !full) begin
            wp_q <= wp_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rp_q <= '0;
        end else if (rd.ready && !empty) begin
            rp_q <= rp_q + 1'b1;
        end
    end
endmodule // ccdseq_fifo
`default_nettype wire

// ---- verilog/ccdseq_top.sv ----
// Purpose: timing controller that sequences the sensor's readout modes
// Assumes: mode and frame request come from logic on clk; pixel samples arrive from pins
// Notes:   mode is latched at frame start and held until the frame ends
`timescale 1ns/10ps
`default_nettype none
module ccdseq_top #(
    parameter int PIX_W        = 12,
    parameter int PIX_PER_LINE = 64,
    parameter int FIFO_DEPTH   = 32
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire ccdseq_pkg::ccdseq_mode_e mode_sel,
    input  wire logic                     rate_fast,
    input  wire logic                     frame_req,
    input  wire logic [PIX_W-1:0]         pix_in,
    input  wire logic                     out_ready,
    output logic                          electrode_group_a,
    output logic                          electrode_group_b,
    output logic                          electrode_group_c,
    output logic                          vshift,
    output logic                          vsweep,
    output logic                          hpix,
    output logic                          line_active,
    output logic                          frame_busy,
    output logic                          frame_done,
    output logic [10:0]                   line_count,
    output logic [PIX_W-1:0]              out_data,
    output logic                          out_valid
);
    import ccdseq_pkg::*;

    initial begin
        if (PIX_PER_LINE < 1 || PIX_PER_LINE > 4095 || FIFO_DEPTH < 2) begin
            $error("unsupported line length or buffer depth");
        end
    end

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RD1  = 7'h02,
        ST_SHF  = 7'h04,
        ST_RD2  = 7'h08,
        ST_SWT  = 7'h10,
        ST_LINE = 7'h20,
        ST_SWB  = 7'h40
    } ccdseq_state_e;

    ccdseq_state_e    st_q;
    ccdseq_state_e    st_d;
    ccdseq_mode_e     mode_q;
    logic             fast_q;
    logic [11:0]      cnt_q;
    logic [10:0]      row_q;
    logic [1:0]       pend_q;
    logic [PIX_W-1:0] pix_s1_q;
    logic [PIX_W-1:0] pix_s2_q;
    logic [11:0]      pix_cnt_q;
    logic             line_end;
    logic             cnt_end;
    logic             row_end;

    ccdseq_stream_if #(.W(PIX_W)) fin ();
    ccdseq_stream_if #(.W(PIX_W)) fout ();

    ccdseq_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk (clk),
        .rst (rst),
        .wr  (fin.snk),
        .rd  (fout.src)
    );

    assign cnt_end  = (cnt_q == 12'h000);
    assign row_end  = (row_q == 11'h000);
    assign line_end = line_active && (pix_cnt_q == 12'h000) && (pend_q == 2'h0) && !hpix;

    // pixel pins pass two flops before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pix_s1_q <= '0;
            pix_s2_q <= '0;
        end else begin
            pix_s1_q <= pix_in;
            pix_s2_q <= pix_s1_q;
        end
    end

    // sample is pushed when its strobe has crossed the two flops
    assign fin.valid = pend_q[1];
    assign fin.data  = pix_s2_q;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: if (frame_req) st_d = ST_RD1;
            ST_RD1:  if (cnt_end) st_d = ccdseq_adds(mode_q) ? ST_SHF : ST_SWT;
            ST_SHF:  if (cnt_end) st_d = ST_RD2;
            ST_RD2:  if (cnt_end) st_d = ST_SWT;
            ST_SWT:  if (row_end) st_d = ST_LINE;
            ST_LINE: if (row_end && line_end) st_d = ST_SWB;
            ST_SWB:  if (row_end) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // mode captured only on frame start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= CCDSEQ_PROG;
            fast_q <= 1'b0;
        end else if (st_q == ST_IDLE && frame_req) begin
            mode_q <= mode_sel;
            fast_q <= rate_fast;
        end
    end

    // readout pulse width and the two-stage shift timing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (st_q == ST_IDLE && frame_req) begin
            cnt_q <= 12'(READOUT_CYC - 1);
        end else if (st_q == ST_RD1 && cnt_end) begin
            cnt_q <= 12'(SHIFT_CYC - 1);
        end else if (st_q == ST_SHF && cnt_end) begin
            cnt_q <= 12'(READOUT_CYC - 1);
        end else if (!cnt_end) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // readout pulses onto electrode groups
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            electrode_group_a <= 1'b0;
            electrode_group_b <= 1'b0;
            electrode_group_c <= 1'b0;
        end else if (st_d == ST_RD1) begin
            electrode_group_a <= ccdseq_first_grp(frame_req && st_q == ST_IDLE
                                                  ? mode_sel : mode_q) == GRP_A ||
                                 ccdseq_first_grp(frame_req && st_q == ST_IDLE
                                                  ? mode_sel : mode_q) == GRP_ALL;
            electrode_group_b <= ccdseq_first_grp(frame_req && st_q == ST_IDLE
                                                  ? mode_sel : mode_q) == GRP_ALL;
            electrode_group_c <= ccdseq_first_grp(frame_req && st_q == ST_IDLE
                                                  ? mode_sel : mode_q) != GRP_A;
        end else if (st_d == ST_RD2) begin
            electrode_group_a <= 1'b1;
            electrode_group_b <= 1'b1;
            electrode_group_c <= 1'b0;
        end else begin
            electrode_group_a <= 1'b0;
            electrode_group_b <= 1'b0;
            electrode_group_c <= 1'b0;
        end
    end

    // row counter: sweep rows, then delivered lines, then sweep rows
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            row_q <= '0;
        end else if (st_q != ST_SWT && st_d == ST_SWT) begin
            row_q <= ccdseq_sweep(mode_q, fast_q);
        end else if (st_q == ST_SWT && row_end) begin
            row_q <= ccdseq_lines(mode_q, fast_q) - 1'b1;
        end else if (st_q == ST_LINE && row_end && line_end) begin
            row_q <= ccdseq_sweep(mode_q, fast_q);
        end else if ((st_q == ST_SWT || st_q == ST_SWB) && !row_end) begin
            row_q <= row_q - 1'b1;
        end else if (st_q == ST_LINE && line_end && !row_end) begin
            row_q <= row_q - 1'b1;
        end
    end

    // one vertical step per swept row and per delivered line
    // shift steps follow st_d so they end before the second readout starts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vshift <= 1'b0;
            vsweep <= 1'b0;
        end else begin
            vshift <= (st_d == ST_SHF) ||
                      ((st_q == ST_SWT || st_q == ST_SWB) && !row_end) ||
                      (st_q == ST_LINE && !line_active);
            vsweep <= (st_q == ST_SWT || st_q == ST_SWB) && !row_end;
        end
    end

    // line window opens in the same cycle as its vertical step; line 1 comes out first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_active <= 1'b0;
        end else if (st_q == ST_LINE && !line_active && !line_end) begin
            line_active <= 1'b1;
        end else if (line_end) begin
            line_active <= 1'b0;
        end
    end

    // pixel strobes stall while the buffer cannot take a word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hpix      <= 1'b0;
            pend_q    <= 2'h0;
            pix_cnt_q <= 12'(PIX_PER_LINE);
        end else begin
            hpix   <= line_active && (pix_cnt_q != 12'h000) && fin.ready &&
                      !hpix && (pend_q == 2'h0);
            pend_q <= {pend_q[0], hpix};
            if (!line_active) begin
                pix_cnt_q <= 12'(PIX_PER_LINE);
            end else if (hpix) begin
                pix_cnt_q <= pix_cnt_q - 1'b1;
            end
        end
    end

    // delivered line count and frame status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_count <= '0;
            frame_busy <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_busy <= (st_d != ST_IDLE);
            frame_done <= (st_q == ST_SWB) && row_end;
            if (st_q == ST_IDLE && frame_req) begin
                line_count <= '0;
            end else if (st_q == ST_LINE && line_end) begin
                line_count <= line_count + 1'b1;
            end
        end
    end

    // registered output stage
    assign fout.ready = !out_valid || out_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (fout.ready) begin
            out_valid <= fout.valid;
            out_data  <= fout.data;
        end
    end
endmodule // ccdseq_top
`default_nettype wire

// ---- sim/ccdseq_top_properties.sv ----
// Purpose: port-level properties of the readout-mode sequencer
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound into every ccdseq_top instance
`timescale 1ns/10ps
`default_nettype none
module ccdseq_top_properties #(
    parameter int PIX_W = 12
) (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire ccdseq_pkg::ccdseq_mode_e mode_sel,
    input wire logic                     electrode_group_a,
    input wire logic                     electrode_group_b,
    input wire logic                     electrode_group_c,
    input wire logic                     vshift,
    input wire logic                     vsweep,
    input wire logic                     hpix,
    input wire logic                     line_active,
    input wire logic                     frame_busy,
    input wire logic [10:0]              line_count,
    input wire logic [PIX_W-1:0]         out_data,
    input wire logic                     out_valid,
    input wire logic                     out_ready
);
    import ccdseq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic         grp;
    logic [7:0]   run_q;
    ccdseq_mode_e m_q;
    assign grp = electrode_group_a | electrode_group_b | electrode_group_c;
    // length of the current readout pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 8'h00;
        end else begin
            run_q <= grp ? run_q + 8'h01 : 8'h00;
        end
    end
    // mode as latched at frame start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m_q <= CCDSEQ_PROG;
        end else if (!frame_busy) begin
            m_q <= mode_sel;
        end
    end
    a_readout_width: assert property (
        $fell(grp) |-> run_q == 8'(READOUT_CYC)) else $error("readout pulse length wrong");
    a_group_select: assert property (
        $rose(frame_busy) |-> {electrode_group_c, electrode_group_b, electrode_group_a} ==
        ((m_q == CCDSEQ_D28 || m_q == CCDSEQ_AF1) ? 3'h1 :
        (m_q inside {[CCDSEQ_D24:CCDSEQ_CS2]}) ? 3'h4 : 3'h7))
        else $error("wrong electrode groups at frame start");
    a_add_shift: assert property (
        $fell(electrode_group_c) && (m_q == CCDSEQ_ADD2 || m_q == CCDSEQ_CS2)
        |-> vshift [*2] ##1 (electrode_group_a && electrode_group_b))
        else $error("addition pass out of order");
    a_sweep_modes: assert property (
        vsweep |-> m_q inside {[CCDSEQ_CS1:CCDSEQ_AF1]}) else $error("sweep in full-area mode");
    a_sweep_no_line: assert property (
        vsweep |-> !line_active && !hpix) else $error("sweep during a line");
    a_strobe_spacing: assert property (
        hpix |-> line_active ##1 !hpix ##1 !hpix) else $error("pixel strobe misplaced");
    a_quiet_idle: assert property (
        !frame_busy |-> !grp && !vshift && !hpix) else $error("activity outside a frame");
    a_out_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output word dropped while stalled");
    a_count_step: assert property (
        $changed(line_count) && line_count != 11'h000 |-> line_count == $past(line_count) + 11'h001)
        else $error("line count skipped");
    c_add_pass: cover property (electrode_group_a && electrode_group_b);
    c_sweep: cover property (vsweep && vshift);
    c_stall: cover property (out_valid && !out_ready);
endmodule // ccdseq_top_properties
bind ccdseq_top ccdseq_top_properties #(.PIX_W(PIX_W)) u_ccdseq_top_properties (
    .clk(clk), .rst(rst), .mode_sel(mode_sel), .electrode_group_a(electrode_group_a),
    .electrode_group_b(electrode_group_b), .electrode_group_c(electrode_group_c),
    .vshift(vshift), .vsweep(vsweep), .hpix(hpix), .line_active(line_active),
    .frame_busy(frame_busy), .line_count(line_count), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));
`default_nettype wire

// ---- sim/ccdseq_sensor_model.sv ----
// Purpose: sensor stand-in returning one numbered sample per pixel strobe
// Assumes: samples count from zero after each readout pulse
// Notes:   past the hold window the pins show the inverse of the last sample
`timescale 1ns/10ps
`default_nettype none
module ccdseq_sensor_model (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   readout,
    input  wire logic   hpix,
    output logic [11:0] pix
);
    logic [11:0] cnt_q;
    logic [11:0] last_q;
    logic        hold_q;
    assign pix = hpix ? cnt_q : (hold_q ? last_q : ~last_q);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= 12'h000;
            last_q <= 12'h000;
            hold_q <= 1'b0;
        end else begin
            hold_q <= hpix;
            if (readout) begin
                cnt_q <= 12'h000;
            end else if (hpix) begin
                cnt_q  <= cnt_q + 12'h001;
                last_q <= cnt_q;
            end
        end
    end
endmodule // ccdseq_sensor_model
`default_nettype wire

// ---- sim/ccd_readout_mode_sequencer_tb.sv ----
// Purpose: self-checking bench for the readout-mode sequencer
// Assumes: 25 MHz clock, lines shortened to 8 pixels
// Notes:   progressive and 2/4 frames are cut short by reset to save run time
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
    $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module ccd_readout_mode_sequencer_tb;
    import ccdseq_pkg::*;
    localparam int PPL = 8;
    logic         clk;
    logic         rst;
    ccdseq_mode_e mode_sel;
    logic         rate_fast;
    logic         frame_req;
    logic [11:0]  pix_in;
    logic         out_ready;
    logic         electrode_group_a;
    logic         electrode_group_b;
    logic         electrode_group_c;
    logic         vshift;
    logic         vsweep;
    logic         hpix;
    logic         line_active;
    logic         frame_busy;
    logic         frame_done;
    logic [10:0]  line_count;
    logic [11:0]  out_data;
    logic         out_valid;
    int           fails;
    int           num_checks;
    ccdseq_top #(.PIX_W(12), .PIX_PER_LINE(PPL), .FIFO_DEPTH(32)) u_ccdseq_top (
        .clk(clk), .rst(rst), .mode_sel(mode_sel), .rate_fast(rate_fast),
        .frame_req(frame_req), .pix_in(pix_in), .out_ready(out_ready),
        .electrode_group_a(electrode_group_a), .electrode_group_b(electrode_group_b),
        .electrode_group_c(electrode_group_c), .vshift(vshift), .vsweep(vsweep),
        .hpix(hpix), .line_active(line_active), .frame_busy(frame_busy),
        .frame_done(frame_done), .line_count(line_count), .out_data(out_data),
        .out_valid(out_valid));
    ccdseq_sensor_model u_ccdseq_sensor_model (
        .clk(clk), .rst(rst), .hpix(hpix), .pix(pix_in),
        .readout(electrode_group_a | electrode_group_b | electrode_group_c));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one whole frame; a second request and a mode change arrive mid-frame
    task automatic run_frame(input ccdseq_mode_e m, input logic f, input logic stall,
                             input int lines, input int rpl);
        int n;
        int words;
        int swp;
        int stop;
        int tail;
        words = 0;
        swp = 0;
        stop = 0;
        tail = 0;
        mode_sel <= m;
        rate_fast <= f;
        frame_req <= 1'b1;
        @(posedge clk);
        frame_req <= 1'b0;
        for (n = 0; n < 40000 && !(tail > 8 && !out_valid); n++) begin
            @(posedge clk);
            if (out_valid && out_ready) begin
                `CHK("pixel", words[11:0], out_data)
                words++;
            end
            if (vsweep && vshift) swp++;
            if (stall && n > 1000 && n < 1200 && hpix) stop++;
            if (tail > 0) tail++;
            if (frame_done) begin
                tail = 1;
                `CHK("lines", lines[10:0], line_count)
            end
            out_ready <= !(stall && n > 300 && n < 1200);
            frame_req <= (n == 10);
            if (n == 10) mode_sel <= ccdseq_mode_e'(m ^ 3'h1);
        end
        if (n >= 40000) begin
            fails++;
            end_sim();
        end
        `CHK("words", lines * PPL, words)
        `CHK("sweep rows", ROWS - lines * rpl, swp)
        `CHK("stalled strobes", 0, stop)
        `CHK("busy after frame", 1'b0, frame_busy)
    endtask
    task automatic t_abort(input ccdseq_mode_e m, input logic [2:0] grp);
        mode_sel <= m;
        frame_req <= 1'b1;
        @(posedge clk);
        frame_req <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("groups", grp, {electrode_group_c, electrode_group_b, electrode_group_a})
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("busy in reset", 1'b0, frame_busy)
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_decimate_stall;
        run_frame(CCDSEQ_D28, 1'b1, 1'b1, 310, 4);
    endtask
    task automatic t_addition;
        run_frame(CCDSEQ_ADD2, 1'b1, 1'b0, 620, 2);
    endtask
    task automatic t_center;
        run_frame(CCDSEQ_CS1, 1'b1, 1'b0, 568, 2);
        run_frame(CCDSEQ_CS2, 1'b0, 1'b0, 434, 2);
        run_frame(CCDSEQ_CS3, 1'b0, 1'b0, 444, 1);
    endtask
    task automatic t_autofocus;
        run_frame(CCDSEQ_AF1, 1'b1, 1'b0, 235, 4);
        run_frame(CCDSEQ_AF1, 1'b0, 1'b0, 170, 4);
    endtask
    initial begin
        fails = 0;
        num_checks = 0;
        rst = 1'b1;
        mode_sel = CCDSEQ_PROG;
        rate_fast = 1'b0;
        frame_req = 1'b0;
        out_ready = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_abort(CCDSEQ_PROG, 3'h7);
        t_abort(CCDSEQ_D24, 3'h4);
        t_decimate_stall();
        t_addition();
        t_center();
        t_autofocus();
        end_sim();
    end
endmodule // ccd_readout_mode_sequencer_tb
`default_nettype wire
